/* wdt_map.svh */
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define WDT_ADDR_W 12
`define WDT_IDX_W 10
`define WDT_IDX_CONTROL 10'h0AA
`define WDT_IDX_BOOT_CFG 10'h0AB
`define WDT_IDX_STATUS 10'h0AC
`define WDT_IDX_MASK 10'h0AD

// ----------------------------------------
// control and configuration fields
// ----------------------------------------
`define WDT_CTL_ENABLE 7
`define WDT_CTL_CLEAR 6
`define WDT_CTL_LOWPOW 4
`define WDT_CTL_FLAG 3
`define WDT_CTL_PS_HI 2
`define WDT_CTL_PS_LO 0
`define WDT_CFG_DISABLE 7
`define WDT_BOOT_CFG_POR 8'hFF
`define WDT_ST_TIMEOUT 0
`define WDT_ST_REJECT 1
`define WDT_ST_W 2

// ----------------------------------------
// timing
// ----------------------------------------
`define WDT_CLK_FREQ_HZ 10000000
`define WDT_RC_FREQ_HZ 10000
`define WDT_RC_CYCLES (`WDT_CLK_FREQ_HZ / `WDT_RC_FREQ_HZ)
`define WDT_RC_DIV_W 10
`define WDT_PRE_W 8
`define WDT_DIV_SHIFTS 32'h87654310
`define WDT_TIMEOUT_PERIODS 64
`define WDT_CNT_W 6

`endif

/* wdt_pkg.sv */
package wdt_pkg;
    // answer codes of the register bus
    typedef enum logic [1:0] {
        RESP_OKAY = 2'h0,
        RESP_SLVERR = 2'h2
    } axi_resp_t;
    // one byte-wide register
    typedef logic [7:0] reg8_t;
endpackage

/* tick_divider.sv */
`timescale 1ns/100ps

// counts steps up to a limit, then wraps and gives one tick
module tick_divider #(
    parameter int W = 8
) (
    input wire logic clk_in, // clock
    input wire logic rstn_in, // synchronous reset, active low
    input wire logic clear_in, // zero the count
    input wire logic step_in, // advance by one
    input wire logic [W-1:0] limit_in, // last count before wrap
    output logic tick_out, // step that wraps
    output logic [W-1:0] count_out // present count
);
    logic [W-1:0] count;

    // wrap pulse, combinational
    assign tick_out = step_in && (count == limit_in) && !clear_in;
    assign count_out = count;

    // count with clear taking priority
    always_ff @(posedge clk_in) begin
        if (!rstn_in || clear_in) begin
            count <= '0;
        end else if (step_in) begin
            if (count == limit_in) begin
                count <= '0;
            end else begin
                count <= count + W'(1);
            end
        end
    end
endmodule

/* system_watchdog_timer.sv */
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "wdt_map.svh"

// Function
// - writing one to counter_clear zeroes the count; bit reads zero, self-clears
// - watchdog_run_enable bit 7 stops counter when zero, runs when one
// - prescale select bits 2:0 choose the time-out interval
// - codes 0..7 divide by 1,2,8,16,32,64,128,256
// - time-out after 64 prescaled periods of the 10kHz RC clock
// - expiry while enabled gives an immediate direct system reset
// - watchdog_reset_flag bit 3 set when the watchdog causes a reset
// - flag cleared by power-on only; software may write it to zero
// - run_in_low_power bit 4 decides counting during idle and power-down
// - counter cleared on entry into and wake from low power (idle or power-down), not on a direct move between idle and power-down
// - after every reset enable takes inverse of configuration bit 7
// - low-power bit and prescale select cleared by power-on only
// - control register written only through timed access protection
module system_watchdog_timer (
    input wire logic CLOCK_IN, // 10 MHz clock
    input wire logic RSTN_IN, // power-on reset, synchronous, active low
    input wire logic SYS_RESET_IN, // any other system reset, active high
    input wire logic IDLE_IN, // cpu in idle mode
    input wire logic POWER_DOWN_IN, // cpu in power-down mode
    input wire logic TIMED_UNLOCK_IN, // timed access window open
    input wire logic [`WDT_ADDR_W-1:0] AWADDR_IN, // write address
    input wire logic AWVALID_IN, // write address valid
    output logic AWREADY_OUT, // write address ready
    input wire logic [31:0] WDATA_IN, // write data
    input wire logic [3:0] WSTRB_IN, // write byte strobes
    input wire logic WVALID_IN, // write data valid
    output logic WREADY_OUT, // write data ready
    output logic [1:0] BRESP_OUT, // write response
    output logic BVALID_OUT, // write response valid
    input wire logic BREADY_IN, // write response ready
    input wire logic [`WDT_ADDR_W-1:0] ARADDR_IN, // read address
    input wire logic ARVALID_IN, // read address valid
    output logic ARREADY_OUT, // read address ready
    output logic [31:0] RDATA_OUT, // read data
    output logic [1:0] RRESP_OUT, // read response
    output logic RVALID_OUT, // read data valid
    input wire logic RREADY_IN, // read data ready
    output logic WDT_RESET_OUT, // one-cycle system reset request
    output logic IRQ_OUT // interrupt, high while unmasked status set
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic enable;
    logic run_lp;
    logic reset_flag;
    logic [2:0] prescale;
    wdt_pkg::reg8_t boot_cfg;
    logic [`WDT_ST_W-1:0] status;
    logic [`WDT_ST_W-1:0] mask;
    logic wdt_reset;
    logic low_power_d;

    logic aw_held;
    logic [`WDT_IDX_W-1:0] aw_idx;
    logic w_held;
    wdt_pkg::reg8_t w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;

    // ----------------------------------------
    // derived signals
    // ----------------------------------------
    logic warm_reset;
    logic low_power;
    logic lp_change;
    logic halted;
    logic wr_fire;
    logic wr_hit;
    logic wr_ctrl;
    logic ctrl_accept;
    logic ctrl_reject;
    logic sw_clear;
    logic cnt_clear;
    logic rc_tick;
    logic pre_tick;
    logic timeout;
    logic [`WDT_PRE_W-1:0] pre_limit;
    logic [3:0] pre_shift;
    logic [`WDT_IDX_W-1:0] ar_idx;
    wdt_pkg::reg8_t rd_byte;
    logic rd_hit;

    localparam logic [31:0] DIV_SHIFTS = `WDT_DIV_SHIFTS;
    localparam logic [`WDT_RC_DIV_W-1:0] RC_LIMIT = `WDT_RC_DIV_W'(`WDT_RC_CYCLES - 1);
    localparam logic [`WDT_CNT_W-1:0] CNT_LIMIT = `WDT_CNT_W'(`WDT_TIMEOUT_PERIODS - 1);
    localparam wdt_pkg::reg8_t BOOT_CFG_POR = `WDT_BOOT_CFG_POR;
    // ----------------------------------------
    // reset and low-power conditions
    // ----------------------------------------

    // resets other than power-on, including the one this block raises
    assign warm_reset = SYS_RESET_IN || wdt_reset;
    assign low_power = IDLE_IN || POWER_DOWN_IN;
    assign lp_change = low_power != low_power_d;
    assign halted = low_power && !run_lp;

    // previous low-power level, for entry and wake edges
    always_ff @(posedge CLOCK_IN) begin
        if (!RSTN_IN) begin
            low_power_d <= 1'b0;
        end else begin
            low_power_d <= low_power;
        end
    end

    // ----------------------------------------
    // write channel
    // ----------------------------------------

    // address and data are taken independently, in either order
    assign AWREADY_OUT = !aw_held;
    assign WREADY_OUT = !w_held;
    assign wr_fire = aw_held && w_held && !bvalid;
    assign wr_hit = (aw_idx == `WDT_IDX_CONTROL) || (aw_idx == `WDT_IDX_BOOT_CFG) ||
                    (aw_idx == `WDT_IDX_STATUS) || (aw_idx == `WDT_IDX_MASK);
    assign wr_ctrl = wr_fire && w_lane0 && (aw_idx == `WDT_IDX_CONTROL);
    assign ctrl_accept = wr_ctrl && TIMED_UNLOCK_IN;
    assign ctrl_reject = wr_ctrl && !TIMED_UNLOCK_IN;
    assign sw_clear = ctrl_accept && w_data[`WDT_CTL_CLEAR];

    // write address holding register
    always_ff @(posedge CLOCK_IN) begin
        if (!RSTN_IN) begin
            aw_held <= 1'b0;
            aw_idx <= '0;
        end else if (AWVALID_IN && !aw_held) begin
            aw_held <= 1'b1;
            aw_idx <= AWADDR_IN[`WDT_ADDR_W-1:2];
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    // write data holding register, only byte lane 0 carries a register
    always_ff @(posedge CLOCK_IN) begin
        if (!RSTN_IN) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_lane0 <= 1'b0;
        end else if (WVALID_IN && !w_held) begin
            w_held <= 1'b1;
            w_data <= WDATA_IN[7:0];
            w_lane0 <= WSTRB_IN[0];
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // write response, error for an unmapped word
    always_ff @(posedge CLOCK_IN) begin
        if (!RSTN_IN) begin
            bvalid <= 1'b0;
            bresp <= wdt_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
        end else if (BREADY_IN) begin
            bvalid <= 1'b0;
        end
    end

    assign BVALID_OUT = bvalid;
    assign BRESP_OUT = bresp;

    // ----------------------------------------
    // control register fields
    // ----------------------------------------

    // enable reloads from the configuration byte on every reset
    always_ff @(posedge CLOCK_IN) begin
        if (!RSTN_IN) begin
            enable <= ~BOOT_CFG_POR[`WDT_CFG_DISABLE];
        end else if (warm_reset) begin
            enable <= ~boot_cfg[`WDT_CFG_DISABLE];
        end else if (ctrl_accept) begin
            enable <= w_data[`WDT_CTL_ENABLE];
        end
    end

    // low-power run and prescale select survive all but power-on
    always_ff @(posedge CLOCK_IN) begin
        if (!RSTN_IN) begin
            run_lp <= 1'b0;
            prescale <= 3'h0;
        end else if (ctrl_accept) begin
            run_lp <= w_data[`WDT_CTL_LOWPOW];
            prescale <= w_data[`WDT_CTL_PS_HI:`WDT_CTL_PS_LO];
        end
    end

    // reset flag: set by a watchdog reset, cleared by power-on or a written zero
    always_ff @(posedge CLOCK_IN) begin
        if (!RSTN_IN) begin
            reset_flag <= 1'b0;
        end else if (wdt_reset) begin
            reset_flag <= 1'b1;
        end else if (ctrl_accept && !w_data[`WDT_CTL_FLAG]) begin
            reset_flag <= 1'b0;
        end
    end

    // configuration byte, loaded as unprogrammed at power-on
    always_ff @(posedge CLOCK_IN) begin
        if (!RSTN_IN) begin
            boot_cfg <= `WDT_BOOT_CFG_POR;
        end else if (wr_fire && w_lane0 && aw_idx == `WDT_IDX_BOOT_CFG) begin
            boot_cfg <= w_data;
        end
    end

    // ----------------------------------------
    // counting chain
    // ----------------------------------------

    // division ratio from the prescale code, as a wrap limit
    assign pre_shift = DIV_SHIFTS[{prescale, 2'h0} +: 4];
    assign pre_limit = `WDT_PRE_W'((9'h001 << pre_shift) - 9'h001);

    // any clear of the watchdog count also restarts the prescaler
    assign cnt_clear = warm_reset || sw_clear || lp_change;

    // stand-in for the low-frequency RC clock, free running
    tick_divider #(
        .W(`WDT_RC_DIV_W)
    ) rc_div (
        .clk_in(CLOCK_IN),
        .rstn_in(RSTN_IN),
        .clear_in(1'b0),
        .step_in(1'b1),
        .limit_in(RC_LIMIT),
        .tick_out(rc_tick),
        .count_out()
    );

    // prescaler, stepped only while enabled and not halted
    tick_divider #(
        .W(`WDT_PRE_W)
    ) pre_div (
        .clk_in(CLOCK_IN),
        .rstn_in(RSTN_IN),
        .clear_in(cnt_clear),
        .step_in(rc_tick && enable && !halted),
        .limit_in(pre_limit),
        .tick_out(pre_tick),
        .count_out()
    );

    // watchdog count, wraps after the full number of prescaled periods
    tick_divider #(
        .W(`WDT_CNT_W)
    ) wdt_cnt (
        .clk_in(CLOCK_IN),
        .rstn_in(RSTN_IN),
        .clear_in(cnt_clear),
        .step_in(pre_tick),
        .limit_in(CNT_LIMIT),
        .tick_out(timeout),
        .count_out()
    );

    // ----------------------------------------
    // system reset output
    // ----------------------------------------

    // direct reset request, one cycle, no interrupt stage first
    always_ff @(posedge CLOCK_IN) begin
        if (!RSTN_IN) begin
            wdt_reset <= 1'b0;
        end else begin
            wdt_reset <= timeout;
        end
    end

    assign WDT_RESET_OUT = wdt_reset;

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------

    // sticky events, write one to clear, a new event wins over the clear
    always_ff @(posedge CLOCK_IN) begin
        if (!RSTN_IN) begin
            status <= '0;
        end else begin
            if (wr_fire && w_lane0 && aw_idx == `WDT_IDX_STATUS) begin
                status <= status & ~w_data[`WDT_ST_W-1:0];
            end
            if (timeout) begin
                status[`WDT_ST_TIMEOUT] <= 1'b1;
            end
            if (ctrl_reject) begin
                status[`WDT_ST_REJECT] <= 1'b1;
            end
        end
    end

    // interrupt mask, same layout as status
    always_ff @(posedge CLOCK_IN) begin
        if (!RSTN_IN) begin
            mask <= '0;
        end else if (wr_fire && w_lane0 && aw_idx == `WDT_IDX_MASK) begin
            mask <= w_data[`WDT_ST_W-1:0];
        end
    end

    assign IRQ_OUT = |(status & mask);

    // ----------------------------------------
    // read channel
    // ----------------------------------------

    assign ar_idx = ARADDR_IN[`WDT_ADDR_W-1:2];
    assign ARREADY_OUT = !rvalid;

    // read data selection; clear bit and reserved bit read zero
    always_comb begin
        rd_byte = '0;
        rd_hit = 1'b1;
        unique case (ar_idx)
            `WDT_IDX_CONTROL: begin
                rd_byte[`WDT_CTL_ENABLE] = enable;
                rd_byte[`WDT_CTL_LOWPOW] = run_lp;
                rd_byte[`WDT_CTL_FLAG] = reset_flag;
                rd_byte[`WDT_CTL_PS_HI:`WDT_CTL_PS_LO] = prescale;
            end
            `WDT_IDX_BOOT_CFG: begin
                rd_byte = boot_cfg;
            end
            `WDT_IDX_STATUS: begin
                rd_byte[`WDT_ST_W-1:0] = status;
            end
            `WDT_IDX_MASK: begin
                rd_byte[`WDT_ST_W-1:0] = mask;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // read answer, held until taken
    always_ff @(posedge CLOCK_IN) begin
        if (!RSTN_IN) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= wdt_pkg::RESP_OKAY;
        end else if (ARVALID_IN && !rvalid) begin
            rvalid <= 1'b1;
            rdata <= {24'h00_0000, rd_byte};
            rresp <= rd_hit ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
        end else if (RREADY_IN) begin
            rvalid <= 1'b0;
        end
    end

    assign RVALID_OUT = rvalid;
    assign RDATA_OUT = rdata;
    assign RRESP_OUT = rresp;

endmodule

/* system_watchdog_timer_assertions.sv */
`timescale 1ns/100ps
`include "wdt_map.svh"

// watches bus handshakes and the reset request pulse at the block's ports
module wdt_checker (
    input wire logic CLOCK_IN, // clock
    input wire logic RSTN_IN, // power-on reset, active low
    input wire logic IDLE_IN, // cpu idle
    input wire logic POWER_DOWN_IN, // cpu power-down
    input wire logic AWVALID_IN, // write address valid
    input wire logic AWREADY_OUT, // write address ready
    input wire logic WVALID_IN, // write data valid
    input wire logic WREADY_OUT, // write data ready
    input wire logic [1:0] BRESP_OUT, // write response
    input wire logic BVALID_OUT, // write response valid
    input wire logic BREADY_IN, // write response ready
    input wire logic [`WDT_ADDR_W-1:0] ARADDR_IN, // read address
    input wire logic ARVALID_IN, // read address valid
    input wire logic ARREADY_OUT, // read address ready
    input wire logic [31:0] RDATA_OUT, // read data
    input wire logic [1:0] RRESP_OUT, // read response
    input wire logic RVALID_OUT, // read data valid
    input wire logic RREADY_IN, // read data ready
    input wire logic WDT_RESET_OUT // reset request
);
    logic [16:0] gap; // cycles since reset release or last request
    logic rd_ctl; // pending read targets the control word

    // ----------------------------------------
    // helper logic
    // ----------------------------------------
    // count cycles between reset requests, saturating
    always_ff @(posedge CLOCK_IN) begin
        if (!RSTN_IN || WDT_RESET_OUT) begin
            gap <= 17'h00000;
        end else if (gap != 17'h1FFFF) begin
            gap <= gap + 17'h00001;
        end
    end

    // remember whether the accepted read address is the control word
    always_ff @(posedge CLOCK_IN) begin
        if (!RSTN_IN) begin
            rd_ctl <= 1'b0;
        end else if (ARVALID_IN && ARREADY_OUT) begin
            rd_ctl <= (ARADDR_IN[`WDT_ADDR_W-1:2] == `WDT_IDX_CONTROL);
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RSTN_IN);

    AST_PULSE_ONE: assert property (WDT_RESET_OUT |=> !WDT_RESET_OUT)
        else $error("reset request longer than one cycle");
    AST_TIMEOUT_GAP: assert property (WDT_RESET_OUT |-> gap >= 17'h0F618)
        else $error("reset request too early");
    AST_MODE_CLEARS: assert property ($changed(IDLE_IN || POWER_DOWN_IN) |=> !WDT_RESET_OUT [*2])
        else $error("reset request right after mode change");
    AST_READ_RESERVED: assert property (RVALID_OUT |-> RDATA_OUT[31:8] == 24'h000000 && (!rd_ctl || RDATA_OUT[6:5] == 2'h0))
        else $error("reserved or write-only read bits not zero");
    AST_WRITE_ANSWER: assert property (AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT |=> ##1 BVALID_OUT)
        else $error("write response late");
    AST_BVALID_HOLD: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
        else $error("write response dropped");
    AST_RVALID_HOLD: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT) && $stable(RRESP_OUT))
        else $error("read answer dropped");
    AST_READ_ANSWER: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT && !ARREADY_OUT)
        else $error("read answer late");
endmodule

/* system_watchdog_timer_bench.sv */
`timescale 1ns/100ps
`include "wdt_map.svh"

module system_watchdog_timer_bench;
    localparam logic [11:0] a_ctl = {`WDT_IDX_CONTROL, 2'h0};
    localparam logic [11:0] a_cfg = {`WDT_IDX_BOOT_CFG, 2'h0};
    localparam logic [11:0] a_st = {`WDT_IDX_STATUS, 2'h0};
    localparam logic [11:0] a_msk = {`WDT_IDX_MASK, 2'h0};
    logic clock_in, rstn_in, sys_reset_in, idle_in, power_down_in, timed_unlock_in;
    logic awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in;
    logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, wdt_reset_out, irq_out;
    logic [11:0] awaddr_in, araddr_in;
    logic [31:0] wdata_in, rdata_out, seed, ctl, v;
    logic [3:0] wstrb_in;
    logic [1:0] bresp_out, rresp_out, r;
    int err_count, checked, n;

    system_watchdog_timer u_system_watchdog_timer (.CLOCK_IN(clock_in), .RSTN_IN(rstn_in),
        .SYS_RESET_IN(sys_reset_in), .IDLE_IN(idle_in), .POWER_DOWN_IN(power_down_in),
        .TIMED_UNLOCK_IN(timed_unlock_in), .AWADDR_IN(awaddr_in), .AWVALID_IN(awvalid_in),
        .AWREADY_OUT(awready_out), .WDATA_IN(wdata_in), .WSTRB_IN(wstrb_in),
        .WVALID_IN(wvalid_in), .WREADY_OUT(wready_out), .BRESP_OUT(bresp_out),
        .BVALID_OUT(bvalid_out), .BREADY_IN(bready_in), .ARADDR_IN(araddr_in),
        .ARVALID_IN(arvalid_in), .ARREADY_OUT(arready_out), .RDATA_OUT(rdata_out),
        .RRESP_OUT(rresp_out), .RVALID_OUT(rvalid_out), .RREADY_IN(rready_in),
        .WDT_RESET_OUT(wdt_reset_out), .IRQ_OUT(irq_out));

    // ----------------------------------------
    // clock, watchdog and helpers
    // ----------------------------------------
    always #50 clock_in = ~clock_in;

    // cut a hang short
    initial begin
        repeat (98000) @(posedge clock_in);
        err_count++;
        end_of_test();
    end

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // control after an unlocked write: flag only clears, clear and bit 5 read zero
    function automatic logic [31:0] exp_ctl(input logic [31:0] p, input logic [7:0] w);
        return {24'h000000, w[7], 2'h0, w[4], p[3] & w[3], w[2:0]};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic unlock);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        seed = next_rand(seed);
        @(posedge clock_in);
        awaddr_in <= a;
        awvalid_in <= 1'b1;
        wdata_in <= {seed[31:8], d};
        wstrb_in <= {seed[3:1], 1'b1};
        wvalid_in <= 1'b1;
        timed_unlock_in <= unlock;
        bready_in <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clock_in);
            if (!aw_done && awready_out) begin
                aw_done = 1'b1;
                awvalid_in <= 1'b0;
            end
            if (!w_done && wready_out) begin
                w_done = 1'b1;
                wvalid_in <= 1'b0;
            end
        end
        do @(posedge clock_in); while (!bvalid_out);
        r = bresp_out;
        bready_in <= 1'b0;
        timed_unlock_in <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] a);
        @(posedge clock_in);
        araddr_in <= a;
        arvalid_in <= 1'b1;
        rready_in <= 1'b1;
        do @(posedge clock_in); while (!arready_out);
        arvalid_in <= 1'b0;
        do @(posedge clock_in); while (!rvalid_out);
        v = rdata_out;
        r = rresp_out;
        rready_in <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        axi_read(a);
        check(what, v, exp);
    endtask

    task automatic pulse_warm();
        @(posedge clock_in);
        sys_reset_in <= 1'b1;
        @(posedge clock_in);
        sys_reset_in <= 1'b0;
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {clock_in, rstn_in, sys_reset_in, idle_in, power_down_in, timed_unlock_in} = 6'h00;
        {awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} = 5'h00;
        {awaddr_in, araddr_in, wdata_in, wstrb_in} = 60'h0;
        err_count = 0;
        checked = 0;
        seed = 32'h00005C37;
        repeat (4) @(posedge clock_in);
        rstn_in <= 1'b1;
        rd_chk("control", a_ctl, 32'h00);
        rd_chk("config", a_cfg, 32'hFF);
        rd_chk("status", a_st, 32'h00);
        rd_chk("mask", a_msk, 32'h00);
        check("irq", irq_out, 1'b0);
        $display("test reset values done");
        ctl = 32'h0;
        for (int c = 0; c < 8; c++) begin
            seed = next_rand(seed);
            ctl = exp_ctl(ctl, {seed[7:3], c[2:0]});
            axi_write(a_ctl, {seed[7:3], c[2:0]}, 1'b1);
            rd_chk("control", a_ctl, ctl);
        end
        $display("test prescale codes done");
        seed = next_rand(seed);
        axi_write(a_ctl, seed[7:0], 1'b0);
        check("bresp", r, wdt_pkg::RESP_OKAY);
        rd_chk("control", a_ctl, ctl);
        rd_chk("status", a_st, 32'h02);
        check("irq", irq_out, 1'b0);
        axi_write(a_msk, 8'h02, 1'b1);
        check("irq", irq_out, 1'b1);
        axi_write(a_st, 8'h02, 1'b1);
        rd_chk("status", a_st, 32'h00);
        check("irq", irq_out, 1'b0);
        axi_write(12'h2B8, 8'hFF, 1'b1);
        check("bresp", r, wdt_pkg::RESP_SLVERR);
        rd_chk("unmapped", 12'h2B8, 32'h00);
        check("rresp", r, wdt_pkg::RESP_SLVERR);
        $display("test protection done");
        axi_write(a_ctl, 8'h17, 1'b1);
        axi_write(a_cfg, 8'h7F, 1'b1);
        pulse_warm();
        rd_chk("control", a_ctl, 32'h97);
        $display("test warm reset done");
        axi_write(a_msk, 8'h01, 1'b1);
        axi_write(a_ctl, 8'hC0, 1'b1);
        rd_chk("control", a_ctl, 32'h80);
        repeat (20000) @(posedge clock_in);
        idle_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        {idle_in, power_down_in} <= 2'h1;
        repeat (4) @(posedge clock_in);
        power_down_in <= 1'b0;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (!wdt_reset_out && n < 70000);
        check("timeout window", n >= 63000 && n <= 65000, 1'b1);
        repeat (2) @(posedge clock_in);
        check("irq", irq_out, 1'b1);
        rd_chk("control", a_ctl, 32'h88);
        pulse_warm();
        rd_chk("control", a_ctl, 32'h88);
        axi_write(a_ctl, 8'h1D, 1'b1);
        rd_chk("control", a_ctl, 32'h1D);
        axi_write(a_ctl, 8'h15, 1'b1);
        rd_chk("control", a_ctl, 32'h15);
        axi_write(a_ctl, 8'h1D, 1'b1);
        $display("test time-out done");
        rstn_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        rstn_in <= 1'b1;
        rd_chk("control", a_ctl, 32'h00);
        rd_chk("status", a_st, 32'h00);
        $display("test power-on reset done");
        end_of_test();
    end
endmodule

bind system_watchdog_timer wdt_checker u_wdt_checker (.CLOCK_IN, .RSTN_IN, .IDLE_IN,
    .POWER_DOWN_IN, .AWVALID_IN, .AWREADY_OUT, .WVALID_IN, .WREADY_OUT, .BRESP_OUT,
    .BVALID_OUT, .BREADY_IN, .ARADDR_IN, .ARVALID_IN, .ARREADY_OUT, .RDATA_OUT, .RRESP_OUT,
    .RVALID_OUT, .RREADY_IN, .WDT_RESET_OUT);
